// ===== inc/pid_cfg.svh
`ifndef PID_CFG_SVH
`define PID_CFG_SVH

// Operation codes whose values are known for the operate function.
`define OP_ADD 32'h0000_0005
`define OP_SUB 32'h0000_000C
`define OP_MUL 32'h0000_0053
`define OP_FMUL 32'h0000_0072
`define OP_DIV 32'h0000_002C
`define OP_REM 32'h0000_001F
`define OP_LADD 32'h0000_0016
`define OP_LSUB 32'h0000_0038
`define OP_LDIV 32'h0000_001A
`define OP_CWORD 32'h0000_0056

// Basic processor cycles per direct function, not counting prefixes.
`define CYC_J 6'h03
`define CYC_ONE 6'h01
`define CYC_TWO 6'h02
`define CYC_CALL 6'h07
`define CYC_OPR 6'h00
`define CYC_PREFIX 6'h01

// One processor cycle is 50 ns at 20 MHz; this block is clocked at 200 MHz.
`define PROC_CYCLE_NS 50
`define CLOCK_MHZ 200
`define PROC_CLKS ((`PROC_CYCLE_NS * `CLOCK_MHZ + 999) / 1000)

`endif

// ===== inc/pid_pkg.sv
package pid_pkg;

	// Function selected by the upper nibble of an instruction byte.
	typedef enum logic [3:0] {
		FN_JUMP = 4'h0, FN_LOCAL_PTR = 4'h1, FN_PREFIX = 4'h2, FN_NL_LOAD = 4'h3,
		FN_LOAD_CONST = 4'h4, FN_NL_PTR = 4'h5, FN_NEG_PREFIX = 4'h6, FN_LOCAL_LOAD = 4'h7,
		FN_ADD_CONST = 4'h8, FN_CALL = 4'h9, FN_COND_JUMP = 4'hA, FN_ADJ_WS = 4'hB,
		FN_EQ_CONST = 4'hC, FN_LOCAL_STORE = 4'hD, FN_NL_STORE = 4'hE, FN_OPERATE = 4'hF
	} fn_t;

endpackage : pid_pkg

// ===== core/instruction_attributes.sv
`timescale 1ns/1ps
`default_nettype none
`include "pid_cfg.svh"

// Operation codes without a fixed value here are parameters; defaults are arbitrary.
module instruction_attributes #(
	parameter logic [31:0] OP_IN_MSG = 32'h0000_00E0,
	parameter logic [31:0] OP_OUT_MSG = 32'h0000_00E1,
	parameter logic [31:0] OP_OUT_BYTE = 32'h0000_00E2,
	parameter logic [31:0] OP_OUT_WORD = 32'h0000_00E3,
	parameter logic [31:0] OP_TALT_WAIT = 32'h0000_00E4,
	parameter logic [31:0] OP_TIMER_IN = 32'h0000_00E5,
	parameter logic [31:0] OP_STOP_ERR = 32'h0000_00E6,
	parameter logic [31:0] OP_ALT_WAIT = 32'h0000_00E7,
	parameter logic [31:0] OP_LOOP_END = 32'h0000_00E8,
	parameter logic [31:0] OP_END_PROC = 32'h0000_00E9,
	parameter logic [31:0] OP_STOP_PROC = 32'h0000_00EA,
	parameter logic [31:0] OP_MULTIPLY = 32'h0000_00EB,
	parameter logic [31:0] OP_SET_ERR = 32'h0000_00EC,
	parameter logic [31:0] OP_TEST_CLR = 32'h0000_00ED,
	parameter logic [31:0] OP_FAULT_MERGE = 32'h0000_00EE,
	parameter logic [31:0] OP_CSUB0 = 32'h0000_00EF,
	parameter logic [31:0] OP_CHECK_SINGLE = 32'h0000_00D0,
	parameter logic [31:0] OP_CCNT1 = 32'h0000_00D1,
	parameter logic [31:0] OP_FP_ENTRY = 32'h0000_00D2,
	parameter logic [63:0] FP_FAULT_SEL = 64'hFFFF_FFFF_FFFF_FFFF
) (
	input wire logic [3:0] fn,
	input wire logic [31:0] operand,
	input wire logic [31:0] selector,
	output logic desched,
	output logic int_fault,
	output logic float_fault,
	output logic fp_entry,
	output logic fault_merge,
	output logic fault_set,
	output logic fault_test_clear
);

	logic opr;
	logic [31:0] op;

	// Zero-operand operations only exist behind the operate function.
	assign opr = (fn == pid_pkg::FN_OPERATE);
	assign op = operand;

	// Only these instructions let the scheduler or a halt request act.
	assign desched = (fn == pid_pkg::FN_JUMP) || (opr && ( // RQ13 RQ18
		op == OP_IN_MSG || op == OP_OUT_MSG || op == OP_OUT_BYTE ||
		op == OP_OUT_WORD || op == OP_TALT_WAIT || op == OP_TIMER_IN ||
		op == OP_STOP_ERR || op == OP_ALT_WAIT || op == OP_LOOP_END ||
		op == OP_END_PROC || op == OP_STOP_PROC));

	// Only these may touch the integer fault flag directly.
	assign int_fault = (fn == pid_pkg::FN_ADD_CONST) || (opr && ( // RQ15 RQ18
		op == `OP_ADD || op == `OP_SUB || op == `OP_REM || op == OP_MULTIPLY ||
		op == `OP_MUL || op == `OP_FMUL || op == `OP_DIV || op == `OP_LADD ||
		op == `OP_LSUB || op == `OP_LDIV || op == OP_SET_ERR || op == OP_TEST_CLR ||
		op == OP_FAULT_MERGE || op == `OP_CWORD || op == OP_CSUB0 ||
		op == OP_CHECK_SINGLE || op == OP_CCNT1));

	// The float flag is owned by the selected subset of floating-point operations.
	assign fp_entry = opr && (op == OP_FP_ENTRY); // RQ9
	assign float_fault = fp_entry && FP_FAULT_SEL[selector[5:0]]; // RQ17 RQ18
	assign fault_merge = opr && (op == OP_FAULT_MERGE);
	assign fault_set = opr && (op == OP_SET_ERR);
	assign fault_test_clear = opr && (op == OP_TEST_CLR);

endmodule : instruction_attributes
`default_nettype wire

// ===== core/prefixed_instruction_decode.sv
// Contract
// (RQ1) An operand below sixteen decodes from one byte with no prefix.
// (RQ2) Larger operands take one prefix byte per extra nibble, high nibble first.
// (RQ3) Negative operands start with a negative prefix byte, function code 6.
// (RQ4) Upper nibble selects one of sixteen functions, zero to F.
// (RQ5) Operation codes below sixteen come in one operate byte.
// (RQ6) Larger operation codes get prefix bytes before the operate byte.
// (RQ7) Every prefix byte costs one extra processor cycle.
// (RQ8) Cycle counts are in processor periods, 50 ns at 20 MHz.
// (RQ9) Floating-point selector comes from the preceding load constant operand.
// (RQ10) The floating-point unit runs alongside the integer processor.
// (RQ11) Variable times follow highest set bit of A or its magnitude.
// (RQ12) Message times count whole words, part words at each end included.
// (RQ13) Processes deschedule only at the listed descheduling instructions.
// (RQ14) A held debug halt request stops at the next descheduling point.
// (RQ15) Only the listed instructions may change the integer fault flag.
// (RQ16) Fault merge sets the integer flag when the float flag is set.
// (RQ17) Only selected floating-point instructions set the float fault flag.
// (RQ18) Each instruction carries descheduling, integer and float fault attributes.
// (RQ19) Prefix ORs nibble then shifts; negative prefix complements first; others clear.
`timescale 1ns/1ps
`default_nettype none
`include "pid_cfg.svh"

module prefixed_instruction_decode #(
	parameter int OPERAND_W = 32,
	parameter int PROC_CLKS = `PROC_CLKS
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	input wire logic debug_halt_request,
	input wire logic int_fault_event,
	input wire logic fp_fault_event,
	input wire logic [OPERAND_W-1:0] reg_a,
	input wire logic [OPERAND_W-1:0] msg_addr,
	input wire logic [OPERAND_W-1:0] msg_len,
	output logic byte_ready_ff,
	output logic issue_valid_ff,
	output logic [3:0] issue_fn_ff,
	output logic [OPERAND_W-1:0] issue_operand_ff,
	output logic [5:0] issue_cycles_ff,
	output logic attr_desched_ff,
	output logic attr_int_fault_ff,
	output logic attr_float_fault_ff,
	output logic fp_issue_ff,
	output logic [OPERAND_W-1:0] fp_selector_ff,
	output logic halted_ff,
	output logic integer_fault_flag_ff,
	output logic float_fault_flag_ff,
	output logic [5:0] a_high_bit_ff,
	output logic [5:0] a_mag_high_bit_ff,
	output logic [OPERAND_W-1:0] msg_words_ff
);

	localparam int WB = OPERAND_W / 8;
	localparam logic [7:0] PACE_LOAD = 8'(PROC_CLKS - 1);

	logic rst_meta_ff, rst_sync_ff;
	logic halt_meta_ff, halt_sync_ff;
	logic [OPERAND_W-1:0] oreg_ff, ldc_operand_ff, full_operand;
	logic [5:0] pfx_cnt_ff;
	logic [7:0] pace_ff, nxt_pace;
	logic take, is_prefix, is_final, nxt_halted;
	logic [3:0] fn;
	logic c_desched, c_int, c_float, c_fp_entry, c_merge, c_set, c_test;
	logic k_merge_ff, k_set_ff, k_test_ff;

	// Highest set bit index; zero when no bit is set.
	function automatic logic [5:0] high_bit(input logic [OPERAND_W-1:0] v);
		logic [5:0] idx;
		idx = 6'h00;
		for (int i = 0; i < OPERAND_W; i++) begin
			if (v[i]) begin
				idx = 6'(i);
			end
		end
		return idx;
	endfunction : high_bit

	// Basic cost of each direct function; operate costs come from the datapath.
	function automatic logic [5:0] base_cycles(input logic [3:0] f);
		logic [5:0] c;
		c = `CYC_ONE;
		unique case (f)
			pid_pkg::FN_JUMP: c = `CYC_J;
			pid_pkg::FN_NL_LOAD, pid_pkg::FN_LOCAL_LOAD, pid_pkg::FN_COND_JUMP,
			pid_pkg::FN_EQ_CONST, pid_pkg::FN_NL_STORE: c = `CYC_TWO;
			pid_pkg::FN_CALL: c = `CYC_CALL;
			pid_pkg::FN_OPERATE: c = `CYC_OPR;
			default: c = `CYC_ONE;
		endcase
		return c;
	endfunction : base_cycles

	// Reset is released through two flops so every flop leaves reset together.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// The halt pin is asynchronous to this clock.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			halt_meta_ff <= 1'b0;
			halt_sync_ff <= 1'b0;
		end else begin
			halt_meta_ff <= debug_halt_request;
			halt_sync_ff <= halt_meta_ff;
		end
	end

	// Byte split and operand assembly.
	assign take = byte_valid && byte_ready_ff;
	assign fn = byte_in[7:4]; // RQ4
	assign is_prefix = (fn == pid_pkg::FN_PREFIX) || (fn == pid_pkg::FN_NEG_PREFIX);
	assign is_final = take && !is_prefix;
	assign full_operand = oreg_ff | {{(OPERAND_W-4){1'b0}}, byte_in[3:0]}; // RQ1

	instruction_attributes u_attr (
		.fn(fn),
		.operand(32'(full_operand)),
		.selector(32'(ldc_operand_ff)),
		.desched(c_desched),
		.int_fault(c_int),
		.float_fault(c_float),
		.fp_entry(c_fp_entry),
		.fault_merge(c_merge),
		.fault_set(c_set),
		.fault_test_clear(c_test)
	);

	// Operand register: a complement before the shift makes the high bits ones.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			oreg_ff <= '0;
		end else if (take) begin
			if (fn == pid_pkg::FN_PREFIX) begin
				oreg_ff <= full_operand << 4; // RQ2 RQ6 RQ19
			end else if (fn == pid_pkg::FN_NEG_PREFIX) begin
				oreg_ff <= (~full_operand) << 4; // RQ3 RQ19
			end else begin
				oreg_ff <= '0; // RQ19
			end
		end
	end

	// Prefix count is folded into the instruction cost.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pfx_cnt_ff <= 6'h00;
		end else if (take) begin
			pfx_cnt_ff <= is_prefix ? pfx_cnt_ff + `CYC_PREFIX : 6'h00; // RQ7
		end
	end

	// Each accepted byte holds the next one off for one processor period.
	always_comb begin
		nxt_pace = pace_ff;
		if (take) begin
			nxt_pace = PACE_LOAD; // RQ7 RQ8
		end else if (pace_ff != 8'h00) begin
			nxt_pace = pace_ff - 8'h01;
		end
	end

	// A halt starts on a descheduling instruction and lasts while the pin is held.
	always_comb begin
		nxt_halted = halted_ff;
		if (!halt_sync_ff) begin
			nxt_halted = 1'b0;
		end else if (is_final && c_desched) begin
			nxt_halted = 1'b1; // RQ14
		end
	end

	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pace_ff <= 8'h00;
			halted_ff <= 1'b0;
			byte_ready_ff <= 1'b0;
		end else begin
			pace_ff <= nxt_pace;
			halted_ff <= nxt_halted;
			byte_ready_ff <= (nxt_pace == 8'h00) && !nxt_halted; // RQ14
		end
	end

	// Issue of a complete instruction with its attributes.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			issue_valid_ff <= 1'b0;
			issue_fn_ff <= 4'h0;
			issue_operand_ff <= '0;
			issue_cycles_ff <= 6'h00;
			attr_desched_ff <= 1'b0;
			attr_int_fault_ff <= 1'b0;
			attr_float_fault_ff <= 1'b0;
		end else begin
			issue_valid_ff <= is_final; // RQ1 RQ5
			if (is_final) begin
				issue_fn_ff <= fn;
				issue_operand_ff <= full_operand;
				issue_cycles_ff <= base_cycles(fn) + pfx_cnt_ff; // RQ7 RQ8
				attr_desched_ff <= c_desched; // RQ18
				attr_int_fault_ff <= c_int; // RQ18
				attr_float_fault_ff <= c_float; // RQ18
			end
		end
	end

	// Floating-point work is handed off without stalling the byte stream.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			ldc_operand_ff <= '0;
			fp_issue_ff <= 1'b0;
			fp_selector_ff <= '0;
		end else begin
			fp_issue_ff <= is_final && c_fp_entry; // RQ10
			if (is_final && c_fp_entry) begin
				fp_selector_ff <= ldc_operand_ff; // RQ9
			end
			if (is_final && fn == pid_pkg::FN_LOAD_CONST) begin
				ldc_operand_ff <= full_operand; // RQ9
			end
		end
	end

	// Kind of fault operation, kept aligned with the issue pulse.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			k_merge_ff <= 1'b0;
			k_set_ff <= 1'b0;
			k_test_ff <= 1'b0;
		end else begin
			k_merge_ff <= is_final && c_merge;
			k_set_ff <= is_final && c_set;
			k_test_ff <= is_final && c_test;
		end
	end

	// Integer flag: a set in the same cycle as a test-and-clear wins.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			integer_fault_flag_ff <= 1'b0;
		end else if ((issue_valid_ff && attr_int_fault_ff && int_fault_event) || // RQ15
			k_set_ff || (k_merge_ff && float_fault_flag_ff)) begin // RQ16
			integer_fault_flag_ff <= 1'b1;
		end else if (k_test_ff) begin
			integer_fault_flag_ff <= 1'b0;
		end
	end

	// Float flag is sticky and driven only by its own instruction subset.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			float_fault_flag_ff <= 1'b0;
		end else if (issue_valid_ff && attr_float_fault_ff && fp_fault_event) begin
			float_fault_flag_ff <= 1'b1; // RQ17
		end
	end

	// Variable-time terms; a partial word at either end counts as a whole word.
	always_ff @(posedge clock or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			a_high_bit_ff <= 6'h00;
			a_mag_high_bit_ff <= 6'h00;
			msg_words_ff <= '0;
		end else begin
			a_high_bit_ff <= high_bit(reg_a); // RQ11
			a_mag_high_bit_ff <= high_bit(reg_a[OPERAND_W-1] ? -reg_a : reg_a); // RQ11
			msg_words_ff <= OPERAND_W'(((msg_addr % WB) + msg_len + WB - 1) / WB); // RQ12
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_ff);

	sequence s_prefix_taken;
		take && fn == pid_pkg::FN_PREFIX;
	endsequence

	sequence s_final_taken;
		is_final && pfx_cnt_ff == 6'h00 && oreg_ff == '0;
	endsequence

	property p_single_byte;
		s_final_taken |=> issue_valid_ff && issue_operand_ff == $past(full_operand)
			&& issue_operand_ff < 16;
	endproperty
	a_single_byte: assert property (p_single_byte) else $error("single byte operand wrong"); // RQ1

	property p_prefix_shift;
		s_prefix_taken |=> oreg_ff == ($past(full_operand) << 4) && !issue_valid_ff;
	endproperty
	a_prefix_shift: assert property (p_prefix_shift) else $error("prefix shift wrong"); // RQ2

	property p_neg_prefix;
		take && fn == pid_pkg::FN_NEG_PREFIX |=> oreg_ff == (~$past(full_operand) << 4);
	endproperty
	a_neg_prefix: assert property (p_neg_prefix) else $error("negative prefix wrong"); // RQ3

	property p_prefix_cost;
		is_final |=> issue_cycles_ff == base_cycles(issue_fn_ff) + $past(pfx_cnt_ff);
	endproperty
	a_prefix_cost: assert property (p_prefix_cost) else $error("prefix cost wrong"); // RQ7

	property p_pacing;
		take |=> !byte_ready_ff;
	endproperty
	a_pacing: assert property (p_pacing) else $error("byte accepted too soon"); // RQ8

	property p_halt;
		is_final && c_desched && halt_sync_ff |=> halted_ff && !byte_ready_ff;
	endproperty
	a_halt: assert property (p_halt) else $error("halt not taken"); // RQ14

	property p_int_cause;
		$rose(integer_fault_flag_ff) |-> $past(issue_valid_ff && attr_int_fault_ff)
			|| $past(k_set_ff) || $past(k_merge_ff);
	endproperty
	a_int_cause: assert property (p_int_cause) else $error("integer flag set without cause"); // RQ15

	property p_merge;
		k_merge_ff && float_fault_flag_ff |=> integer_fault_flag_ff;
	endproperty
	a_merge: assert property (p_merge) else $error("fault merge missed"); // RQ16

	property p_float_cause;
		$rose(float_fault_flag_ff) |-> $past(issue_valid_ff && attr_float_fault_ff);
	endproperty
	a_float_cause: assert property (p_float_cause) else $error("float flag set without cause"); // RQ17

	property p_fp_select;
		fp_issue_ff |-> fp_selector_ff == $past(ldc_operand_ff);
	endproperty
	a_fp_select: assert property (p_fp_select) else $error("fp selector wrong"); // RQ9

	property p_no_desched_ldc;
		issue_valid_ff && issue_fn_ff == pid_pkg::FN_LOAD_CONST |-> !attr_desched_ff;
	endproperty
	a_no_desched_ldc: assert property (p_no_desched_ldc) else $error("ldc marked desched"); // RQ13

endmodule : prefixed_instruction_decode
`default_nettype wire

// ===== tb/fetch_model.sv
`timescale 1ns/1ps
`default_nettype none

// Fetch unit and datapath stand-in: offers queued bytes and reports faults on issue.
module fetch_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic byte_ready_ff,
	input wire logic issue_valid_ff,
	input wire logic int_bad,
	input wire logic fp_bad,
	output logic byte_valid,
	output logic [7:0] byte_in,
	output logic int_fault_event,
	output logic fp_fault_event
);
	logic [7:0] fifo[$];

	task automatic push(input logic [7:0] b);
		fifo.push_back(b);
	endtask : push

	// A byte stays offered until the decoder takes it; idle data toggles so a stale value never looks valid.
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			byte_valid <= 1'b0;
			byte_in <= 8'hA5;
		end else if (byte_valid && byte_ready_ff && fifo.size() > 0) begin
			byte_in <= fifo.pop_front();
		end else if (byte_valid && byte_ready_ff) begin
			byte_valid <= 1'b0;
			byte_in <= ~byte_in;
		end else if (!byte_valid && fifo.size() > 0) begin
			byte_valid <= 1'b1;
			byte_in <= fifo.pop_front();
		end else if (!byte_valid) begin
			byte_in <= ~byte_in;
		end
	end

	// Faults are reported only in the cycle of an issue, as the decoder samples them.
	assign int_fault_event = issue_valid_ff & int_bad;
	assign fp_fault_event = issue_valid_ff & fp_bad;
endmodule : fetch_model

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int PCLK = 10;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic debug_halt_request = 1'b0;
	logic int_bad = 1'b0;
	logic fp_bad = 1'b0;
	logic [31:0] reg_a = 32'h0000_0000;
	logic [31:0] msg_addr = 32'h0000_0000;
	logic [31:0] msg_len = 32'h0000_0001;
	logic byte_valid, byte_ready_ff, issue_valid_ff, attr_desched_ff, attr_int_fault_ff;
	logic attr_float_fault_ff, halted_ff, integer_fault_flag_ff, float_fault_flag_ff, fp_issue_ff;
	logic [7:0] codes [9] = '{8'h05, 8'h0C, 8'h53, 8'h72, 8'h2C, 8'h1F, 8'h38, 8'h1A, 8'h56};
	logic int_fault_event, fp_fault_event;
	logic [7:0] byte_in;
	logic [3:0] issue_fn_ff;
	logic [5:0] issue_cycles_ff, a_high_bit_ff, a_mag_high_bit_ff;
	logic [31:0] issue_operand_ff, fp_selector_ff, msg_words_ff;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int last_take = 0;
	logic held = 1'b0;

	prefixed_instruction_decode #(.PROC_CLKS(PCLK)) i_prefixed_instruction_decode (
		.clock(clock), .arst_n(arst_n), .byte_valid(byte_valid), .byte_in(byte_in),
		.debug_halt_request(debug_halt_request), .int_fault_event(int_fault_event),
		.fp_fault_event(fp_fault_event), .reg_a(reg_a), .msg_addr(msg_addr), .msg_len(msg_len),
		.byte_ready_ff(byte_ready_ff), .issue_valid_ff(issue_valid_ff), .issue_fn_ff(issue_fn_ff),
		.issue_operand_ff(issue_operand_ff), .issue_cycles_ff(issue_cycles_ff),
		.attr_desched_ff(attr_desched_ff), .attr_int_fault_ff(attr_int_fault_ff),
		.attr_float_fault_ff(attr_float_fault_ff), .fp_issue_ff(fp_issue_ff),
		.fp_selector_ff(fp_selector_ff),
		.halted_ff(halted_ff), .integer_fault_flag_ff(integer_fault_flag_ff),
		.float_fault_flag_ff(float_fault_flag_ff), .a_high_bit_ff(a_high_bit_ff),
		.a_mag_high_bit_ff(a_mag_high_bit_ff), .msg_words_ff(msg_words_ff));

	fetch_model i_fetch_model (
		.clock(clock), .arst_n(arst_n), .byte_ready_ff(byte_ready_ff),
		.issue_valid_ff(issue_valid_ff), .int_bad(int_bad), .fp_bad(fp_bad),
		.byte_valid(byte_valid), .byte_in(byte_in), .int_fault_event(int_fault_event),
		.fp_fault_event(fp_fault_event));

	// The clock toggles every 2.5 ns, a period of 5 ns.
	always #2.5 clock = ~clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	function automatic logic [5:0] basic(input logic [3:0] fn);
		case (fn)
			4'h0: basic = 6'h03;
			4'h9: basic = 6'h07;
			4'h3, 4'h7, 4'hA, 4'hC, 4'hE: basic = 6'h02;
			4'hF: basic = 6'h00;
			default: basic = 6'h01;
		endcase
	endfunction : basic

	function automatic logic exp_d(input logic [3:0] fn, input logic [31:0] op);
		exp_d = fn == 4'h0 || (fn == 4'hF && op inside {[32'h0000_00E0:32'h0000_00EA]});
	endfunction : exp_d

	function automatic logic exp_e(input logic [3:0] fn, input logic [31:0] op);
		exp_e = fn == 4'h8 || (fn == 4'hF && op inside {32'h05, 32'h0C, 32'h53, 32'h72, 32'h2C,
			32'h1F, 32'h16, 32'h38, 32'h1A, 32'h56, [32'hEB:32'hEF], 32'hD0, 32'hD1});
	endfunction : exp_e

	function automatic logic [5:0] top_bit(input logic [31:0] v);
		top_bit = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) top_bit = 6'(i);
		end
	endfunction : top_bit

	// Waits a bounded time for the next issue, then checks every issued field.
	task automatic expect_issue(input logic [3:0] fn, input logic [31:0] op, input logic [5:0] cy);
		int t;
		t = 0;
		while (issue_valid_ff !== 1'b1 && t < 200) begin
			@(posedge clock);
			#1;
			t++;
		end
		check(32'(t < 200), 32'h1);
		check(issue_fn_ff, fn);
		check(issue_operand_ff, op);
		check(issue_cycles_ff, cy);
		check(attr_desched_ff, exp_d(fn, op));
		check(attr_int_fault_ff, exp_e(fn, op));
		check(attr_float_fault_ff, fn == 4'hF && op == 32'hD2);
		check(fp_issue_ff, fn == 4'hF && op == 32'hD2);
		@(posedge clock);
		#1;
	endtask : expect_issue

	// Encodes a non-negative operand with prefixes, high nibble first.
	task automatic send_val(input logic [3:0] fn, input logic [31:0] val);
		int n;
		n = 1;
		while (n < 8 && (val >> (4 * n)) != 0) n++;
		for (int i = n - 1; i > 0; i--) i_fetch_model.push({4'h2, val[4*i +: 4]});
		i_fetch_model.push({fn, val[3:0]});
		expect_issue(fn, val, basic(fn) + 6'(n - 1));
	endtask : send_val

	// Consecutive takes of a continuously offered byte sit one processor cycle apart.
	always @(posedge clock) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			give_verdict();
		end
		if (byte_valid && byte_ready_ff) begin
			if (held) check(cyc - last_take, PCLK);
			last_take = cyc;
			held = 1'b1;
		end else if (!byte_valid || halted_ff) begin
			held = 1'b0;
		end
	end

	initial begin
		logic [3:0] f;
		logic [31:0] v;
		void'($urandom(51786));
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
		// Every non-prefix function as a single byte, then known operate codes.
		for (int k = 0; k < 16; k++) begin
			if (k != 2 && k != 6) send_val(4'(k), 32'($urandom_range(0, 15)));
		end
		foreach (codes[j]) send_val(4'hF, 32'(codes[j]));
		for (int o = 32'hD0; o <= 32'hEF; o++) send_val(4'hF, 32'(o));
		send_val(4'hF, 32'h53);
		send_val(4'hF, 32'h72);
		// Documented multi-byte encodings, including the negative one.
		i_fetch_model.push(8'h29);
		i_fetch_model.push(8'h28);
		i_fetch_model.push(8'h47);
		expect_issue(4'h4, 32'h0000_0987, 6'h03);
		i_fetch_model.push(8'h61);
		i_fetch_model.push(8'h41);
		expect_issue(4'h4, 32'hFFFF_FFE1, 6'h02);
		i_fetch_model.push(8'h21);
		i_fetch_model.push(8'hF6);
		expect_issue(4'hF, 32'h0000_0016, 6'h01);
		// Random operands of random widths on non-operate functions, with random fault reports.
		repeat (20) begin
			f = 4'($urandom_range(0, 14));
			if (f == 4'h2 || f == 4'h6) f = 4'h1;
			int_bad <= 1'($urandom);
			fp_bad <= 1'($urandom);
			send_val(f, $urandom >> $urandom_range(0, 31));
		end
		// The random reports may have set the integer flag through add constant; clear it.
		int_bad <= 1'b0;
		fp_bad <= 1'b0;
		send_val(4'hF, 32'hED);
		check(float_fault_flag_ff, 1'b0);
		// Integer flag moves only on listed operations; test-clear drops it.
		int_bad <= 1'b1;
		send_val(4'h4, 32'h3);
		check(integer_fault_flag_ff, 1'b0);
		send_val(4'hF, 32'h5);
		check(integer_fault_flag_ff, 1'b1);
		int_bad <= 1'b0;
		send_val(4'hF, 32'hED);
		check(integer_fault_flag_ff, 1'b0);
		send_val(4'hF, 32'hEC);
		check(integer_fault_flag_ff, 1'b1);
		send_val(4'hF, 32'hED);
		// Float fault comes from the selected entry only; merge then copies it across.
		fp_bad <= 1'b1;
		send_val(4'h4, 32'h5);
		check(float_fault_flag_ff, 1'b0);
		send_val(4'hF, 32'hD2);
		fp_bad <= 1'b0;
		check(fp_selector_ff, 32'h5);
		check(float_fault_flag_ff, 1'b1);
		check(integer_fault_flag_ff, 1'b0);
		send_val(4'hF, 32'hEE);
		check(integer_fault_flag_ff, 1'b1);
		// A held halt request stops the core only at a descheduling instruction.
		debug_halt_request <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		send_val(4'h7, 32'h2);
		check(halted_ff, 1'b0);
		send_val(4'h0, 32'h1);
		check(halted_ff, 1'b1);
		i_fetch_model.push(8'h43);
		repeat (30) @(posedge clock);
		#1;
		check(byte_ready_ff, 1'b0);
		check(issue_fn_ff, 4'h0);
		debug_halt_request <= 1'b0;
		expect_issue(4'h4, 32'h3, 6'h01);
		check(halted_ff, 1'b0);
		// Bit-position and message-span helpers, corners first.
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 32'h0 : (i == 1) ? 32'h8000_0000 : (i == 2) ? 32'hFFFF_FFFF : $urandom;
			reg_a <= v;
			msg_addr <= {2'b00, 30'($urandom)};
			msg_len <= 32'($urandom_range(1, 64));
			@(posedge clock);
			#1;
			check(a_high_bit_ff, top_bit(v));
			check(a_mag_high_bit_ff, top_bit(v[31] ? -v : v));
			check(msg_words_ff, ((msg_addr + msg_len - 1) >> 2) - (msg_addr >> 2) + 1);
		end
		give_verdict();
	end
endmodule : testbench

`default_nettype wire
